// ==== src/c8dp_core.sv ====
// execution datapath with apb register access
`timescale 1ns/1ps
`include "c8dp_map.svh"
module c8dp_core (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        irq_in,
  output logic             swi_out,
  output logic             halted_out
);
  // ==========================================================
  // reset release
  logic rst_s_q;
  logic rst_n;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_s_q <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      rst_s_q <= 1'b1;
      rst_n   <= rst_s_q;
    end
  end

  // ==========================================================
  // interrupt pin synchroniser
  logic irq_s1_q;
  logic irq_s2_q;
  logic irq_s3_q;
  logic irq_lvl_q;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_s1_q  <= 1'b0;
      irq_s2_q  <= 1'b0;
      irq_s3_q  <= 1'b0;
      irq_lvl_q <= 1'b0;
    end
    else
    begin
      irq_s1_q <= irq_in;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      // glitch guard: accept a change only once two stages agree
      if (irq_s2_q == irq_s3_q)
      begin
        irq_lvl_q <= irq_s3_q;
      end
    end
  end

  // ==========================================================
  // state
  c8dp_pkg::c8dp_op_t  op_q;
  c8dp_pkg::c8dp_sel_t dst_q;
  c8dp_pkg::c8dp_sel_t src_q;
  c8dp_pkg::c8dp_st_t  st_q;
  logic [7:0]          gpr_q [4];
  logic                i1_q, h_q, i0_q, n_q, z_q, c_q;
  logic [5:0]          sp_q;
  logic [15:0]         pc_q;
  logic                br_q;
  logic [7:0]          flags_b;
  logic [7:0]          val;
  logic [7:0]          srcv;
  logic [7:0]          res;
  logic                nf, zf, cf, hf, wb, nz, to_a, taken;
  logic [15:0]         prod;
  logic [15:0]         disp;
  logic                exec, popd, setup, wr_ok, hit;
  c8dp_stk_if          stk ();

  c8dp_stack_mem u_stk (
    .clk_in (clk_in),
    .bus    (stk)
  );

  localparam logic [7:0] GOFF [4] = '{`C8DP_OFF_A, `C8DP_OFF_X,
                                      `C8DP_OFF_Y, `C8DP_OFF_OPND};

  assign exec    = (st_q == c8dp_pkg::ST_EXEC);
  assign popd    = (st_q == c8dp_pkg::ST_POPRD);
  assign flags_b = {2'b00, i1_q, h_q, i0_q, n_q, z_q, c_q};
  assign val     = gpr_q[dst_q];
  assign srcv    = gpr_q[src_q];
  assign prod    = 16'(gpr_q[c8dp_pkg::SEL_X]) * 16'(gpr_q[c8dp_pkg::SEL_A]);
  assign disp    = {{8{gpr_q[c8dp_pkg::SEL_M][7]}}, gpr_q[c8dp_pkg::SEL_M]};
  assign taken   = c_q | z_q;
  assign halted_out = (st_q == c8dp_pkg::ST_HALT);

  // ==========================================================
  // apb slave: zero wait states, errors decided in setup
  assign setup      = psel_in & ~penable_in;
  assign wr_ok      = psel_in & penable_in & pwrite_in & ~pslverr_out;
  assign pready_out = 1'b1;

  always_comb
  begin
    case (paddr_in)
      `C8DP_OFF_A, `C8DP_OFF_X, `C8DP_OFF_Y, `C8DP_OFF_FLAGS, `C8DP_OFF_SP,
      `C8DP_OFF_OPND, `C8DP_OFF_CMD, `C8DP_OFF_STAT, `C8DP_OFF_PC: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_out <= ~hit;
      case (paddr_in)
        `C8DP_OFF_A:     prdata_out <= {24'h0, gpr_q[c8dp_pkg::SEL_A]};
        `C8DP_OFF_X:     prdata_out <= {24'h0, gpr_q[c8dp_pkg::SEL_X]};
        `C8DP_OFF_Y:     prdata_out <= {24'h0, gpr_q[c8dp_pkg::SEL_Y]};
        `C8DP_OFF_OPND:  prdata_out <= {24'h0, gpr_q[c8dp_pkg::SEL_M]};
        `C8DP_OFF_FLAGS: prdata_out <= {24'h0, flags_b};
        `C8DP_OFF_SP:    prdata_out <= {26'h0, sp_q};
        `C8DP_OFF_CMD:   prdata_out <= {18'h0, src_q, 2'h0, dst_q, 3'h0, op_q};
        `C8DP_OFF_STAT:  prdata_out <= {29'h0, br_q, halted_out, st_q != c8dp_pkg::ST_IDLE};
        `C8DP_OFF_PC:    prdata_out <= {16'h0, pc_q};
        default:         prdata_out <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // command sequencer; commands written while busy are dropped
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q  <= c8dp_pkg::ST_IDLE;
      op_q  <= c8dp_pkg::OP_IDLE;
      dst_q <= c8dp_pkg::SEL_A;
      src_q <= c8dp_pkg::SEL_A;
    end
    else
    begin
      case (st_q)
        c8dp_pkg::ST_IDLE:
        begin
          if (wr_ok && paddr_in == `C8DP_OFF_CMD)
          begin
            op_q  <= c8dp_pkg::c8dp_op_t'(pwdata_in[`C8DP_CMD_OP]);
            dst_q <= c8dp_pkg::c8dp_sel_t'(pwdata_in[`C8DP_CMD_DST]);
            src_q <= c8dp_pkg::c8dp_sel_t'(pwdata_in[`C8DP_CMD_SRC]);
            st_q  <= c8dp_pkg::ST_EXEC;
          end
        end
        c8dp_pkg::ST_EXEC:
        begin
          if (op_q == c8dp_pkg::OP_POP)
          begin
            st_q <= c8dp_pkg::ST_POPRD;
          end
          else if (op_q == c8dp_pkg::OP_HALT)
          begin
            st_q <= c8dp_pkg::ST_HALT;
          end
          else
          begin
            st_q <= c8dp_pkg::ST_IDLE;
          end
        end
        c8dp_pkg::ST_POPRD: st_q <= c8dp_pkg::ST_IDLE;
        c8dp_pkg::ST_HALT:
        begin
          if (irq_lvl_q)
          begin
            st_q <= c8dp_pkg::ST_IDLE;
          end
        end
        default: st_q <= c8dp_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // arithmetic and logic unit
  always_comb
  begin
    res  = val;
    cf   = c_q;
    hf   = h_q;
    wb   = 1'b0;
    nz   = 1'b0;
    to_a = 1'b0;
    case (op_q)
      c8dp_pkg::OP_MOVE: begin res = srcv; wb = 1'b1; nz = 1'b1; end
      c8dp_pkg::OP_PROD: begin hf = 1'b0; cf = 1'b0; end
      c8dp_pkg::OP_NEG:
      begin
        res = 8'h00 - val;
        cf  = (val != 8'h00);
        wb  = 1'b1;
        nz  = 1'b1;
      end
      c8dp_pkg::OP_OR:  begin res = gpr_q[0] | gpr_q[3]; to_a = 1'b1; nz = 1'b1; end
      c8dp_pkg::OP_XOR: begin res = gpr_q[0] ^ gpr_q[3]; to_a = 1'b1; nz = 1'b1; end
      c8dp_pkg::OP_SUB:
      begin
        {cf, res} = {1'b0, gpr_q[0]} - {1'b0, gpr_q[3]};
        to_a = 1'b1;
        nz   = 1'b1;
      end
      c8dp_pkg::OP_SBC:
      begin
        {cf, res} = {1'b0, gpr_q[0]} - {1'b0, gpr_q[3]} - {8'h00, c_q};
        to_a = 1'b1;
        nz   = 1'b1;
      end
      c8dp_pkg::OP_SLA, c8dp_pkg::OP_SLL:
      begin
        {cf, res} = {val, 1'b0};
        wb = 1'b1;
        nz = 1'b1;
      end
      c8dp_pkg::OP_SRL:  begin {res, cf} = {1'b0, val}; wb = 1'b1; nz = 1'b1; end
      c8dp_pkg::OP_SRA:  begin {res, cf} = {val[7], val}; wb = 1'b1; nz = 1'b1; end
      c8dp_pkg::OP_RLC:  begin {cf, res} = {val, c_q}; wb = 1'b1; nz = 1'b1; end
      c8dp_pkg::OP_RRC:  begin {res, cf} = {c_q, val}; wb = 1'b1; nz = 1'b1; end
      c8dp_pkg::OP_SWAP: begin res = {val[3:0], val[7:4]}; wb = 1'b1; nz = 1'b1; end
      c8dp_pkg::OP_TEST: nz = 1'b1;
      c8dp_pkg::OP_CLRC: cf = 1'b0;
      c8dp_pkg::OP_SETC: cf = 1'b1;
      default: res = val;
    endcase
    nf = nz ? res[7] : n_q;
    zf = nz ? (res == 8'h00) : z_q;
  end

  // ==========================================================
  // operand registers, one copy of the logic per register
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_gpr
      always_ff @(posedge clk_in or negedge rst_n)
      begin
        if (!rst_n)
        begin
          gpr_q[gi] <= `C8DP_RST_BYTE;
        end
        else if (exec && op_q == c8dp_pkg::OP_PROD && gi == 0)
        begin
          gpr_q[gi] <= prod[7:0];
        end
        else if (exec && op_q == c8dp_pkg::OP_PROD && gi == 1)
        begin
          gpr_q[gi] <= prod[15:8];
        end
        else if (exec && ((wb && dst_q == gi) || (to_a && gi == 0)))
        begin
          gpr_q[gi] <= res;
        end
        else if (popd && dst_q == gi && gi != 3)
        begin
          gpr_q[gi] <= stk.rdata;
        end
        else if (wr_ok && paddr_in == GOFF[gi])
        begin
          gpr_q[gi] <= pwdata_in[7:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // flags; trap and halt mask changes take the exec edge
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {i1_q, i0_q} <= {`C8DP_RST_I, `C8DP_RST_I};
      {h_q, n_q, z_q, c_q} <= 4'h0;
    end
    else if (exec)
    begin
      {h_q, n_q, z_q, c_q} <= {hf, nf, zf, cf};
      case (op_q)
        c8dp_pkg::OP_ION:  {i1_q, i0_q} <= 2'b10;
        c8dp_pkg::OP_IOFF: {i1_q, i0_q} <= 2'b11;
        c8dp_pkg::OP_TRAP: {i1_q, i0_q} <= 2'b11;
        c8dp_pkg::OP_HALT: {i1_q, i0_q} <= 2'b10;
        default: {i1_q, i0_q} <= {i1_q, i0_q};
      endcase
    end
    else if (popd && dst_q == c8dp_pkg::SEL_M)
    begin
      i1_q <= stk.rdata[`C8DP_F_I1];
      h_q  <= stk.rdata[`C8DP_F_H];
      i0_q <= stk.rdata[`C8DP_F_I0];
      n_q  <= stk.rdata[`C8DP_F_N];
      z_q  <= stk.rdata[`C8DP_F_Z];
      c_q  <= stk.rdata[`C8DP_F_C];
    end
    else if (wr_ok && paddr_in == `C8DP_OFF_FLAGS)
    begin
      i1_q <= pwdata_in[`C8DP_F_I1];
      h_q  <= pwdata_in[`C8DP_F_H];
      i0_q <= pwdata_in[`C8DP_F_I0];
      n_q  <= pwdata_in[`C8DP_F_N];
      z_q  <= pwdata_in[`C8DP_F_Z];
      c_q  <= pwdata_in[`C8DP_F_C];
    end
  end

  // ==========================================================
  // stack; grows downward, wraps silently on overflow
  assign stk.we    = exec && op_q == c8dp_pkg::OP_PUSH;
  assign stk.waddr = sp_q;
  assign stk.wdata = (dst_q == c8dp_pkg::SEL_M) ? flags_b : val;
  assign stk.raddr = sp_q + 6'h1;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sp_q <= `C8DP_SP_MAX;
    end
    else if (exec && op_q == c8dp_pkg::OP_PUSH)
    begin
      sp_q <= sp_q - 6'h1;
    end
    else if (exec && op_q == c8dp_pkg::OP_POP)
    begin
      sp_q <= sp_q + 6'h1;
    end
    else if (exec && op_q == c8dp_pkg::OP_RSP)
    begin
      sp_q <= `C8DP_SP_MAX;
    end
  end

  // ==========================================================
  // program counter, branch status and trap pulse
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_q    <= `C8DP_RST_PC;
      br_q    <= 1'b0;
      swi_out <= 1'b0;
    end
    else
    begin
      swi_out <= exec && op_q == c8dp_pkg::OP_TRAP;
      if (exec && op_q == c8dp_pkg::OP_BR)
      begin
        br_q <= taken;
        pc_q <= pc_q + 16'h1 + (taken ? disp : 16'h0);
      end
      else if (exec)
      begin
        pc_q <= pc_q + 16'h1;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence pop_go_s;
    exec && op_q == c8dp_pkg::OP_POP;
  endsequence
  sequence pop_done_s;
    popd ##1 (st_q == c8dp_pkg::ST_IDLE);
  endsequence

  branch_taken_a: assert property (exec && op_q == c8dp_pkg::OP_BR && taken
    |=> pc_q == $past(pc_q) + 16'h1 + $past(disp)) else $error("branch target wrong");
  branch_seq_a: assert property (exec && op_q == c8dp_pkg::OP_BR && !taken
    |=> pc_q == $past(pc_q) + 16'h1) else $error("branch not sequential");
  product_xa_a: assert property (exec && op_q == c8dp_pkg::OP_PROD
    |=> {gpr_q[1], gpr_q[0]} == 16'($past(gpr_q[1])) * 16'($past(gpr_q[0]))
        && !h_q && !c_q) else $error("product wrong");
  minus_borrow_a: assert property (exec && op_q == c8dp_pkg::OP_SBC && !wr_ok
    |=> gpr_q[0] == $past(gpr_q[0]) - $past(gpr_q[3]) - {7'h0, $past(c_q)})
    else $error("subtract with carry wrong");
  right_logic_a: assert property (exec && op_q == c8dp_pkg::OP_SRL
    |=> !n_q && c_q == $past(val[0])) else $error("right shift flags wrong");
  rotate_left_a: assert property (exec && op_q == c8dp_pkg::OP_RLC
    |=> c_q == $past(val[7])) else $error("rotate carry wrong");
  carry_ops_a: assert property (exec
    && op_q inside {c8dp_pkg::OP_CLRC, c8dp_pkg::OP_SETC}
    |=> c_q == ($past(op_q) == c8dp_pkg::OP_SETC)) else $error("carry op wrong");
  mask_on_a: assert property (exec && op_q == c8dp_pkg::OP_ION
    |=> i1_q && !i0_q) else $error("mask not 10");
  mask_off_a: assert property (exec && op_q == c8dp_pkg::OP_IOFF
    |=> i1_q && i0_q) else $error("mask not 11");
  trap_pulse_a: assert property (exec && op_q == c8dp_pkg::OP_TRAP
    |=> swi_out && i1_q && i0_q ##1 !swi_out) else $error("trap pulse wrong");
  halt_wait_a: assert property (exec && op_q == c8dp_pkg::OP_HALT
    |=> halted_out && i1_q && !i0_q) else $error("halt entry wrong");
  pop_steps_a: assert property (pop_go_s |=> pop_done_s)
    else $error("pop sequence wrong");
  push_flags_a: assert property (exec && op_q == c8dp_pkg::OP_PUSH
    |=> $stable(flags_b) && sp_q == $past(sp_q) - 6'h1) else $error("push changed flags");
  idle_op_a: assert property (exec && op_q == c8dp_pkg::OP_IDLE && !wr_ok
    |=> $stable(flags_b) && $stable(gpr_q[0]) && pc_q == $past(pc_q) + 16'h1)
    else $error("idle op changed state");
endmodule // c8dp_core

// ==== src/c8dp_map.svh ====
// register map, field positions and reset values of the 8-bit datapath
// ==========================================================
`ifndef C8DP_MAP_SVH
`define C8DP_MAP_SVH
// ==========================================================
// register offsets
`define C8DP_OFF_A     8'h00
`define C8DP_OFF_X     8'h04
`define C8DP_OFF_Y     8'h08
`define C8DP_OFF_FLAGS 8'h0c
`define C8DP_OFF_SP    8'h10
`define C8DP_OFF_OPND  8'h14
`define C8DP_OFF_CMD   8'h18
`define C8DP_OFF_STAT  8'h1c
`define C8DP_OFF_PC    8'h20
// ==========================================================
// command fields
`define C8DP_CMD_OP    4:0
`define C8DP_CMD_DST   9:8
`define C8DP_CMD_SRC   13:12
// ==========================================================
// flag bit positions in the flags register
`define C8DP_F_C  0
`define C8DP_F_Z  1
`define C8DP_F_N  2
`define C8DP_F_I0 3
`define C8DP_F_H  4
`define C8DP_F_I1 5
// ==========================================================
// status bits
`define C8DP_S_BUSY 0
`define C8DP_S_HALT 1
`define C8DP_S_BR   2
// ==========================================================
// reset values and sizes
`define C8DP_SP_MAX   6'h3f
`define C8DP_STK_AW   6
`define C8DP_STK_DEP  64
`define C8DP_RST_BYTE 8'h00
`define C8DP_RST_PC   16'h0000
`define C8DP_RST_I    1'b1
`endif

// ==== src/c8dp_pkg.sv ====
// types shared by the 8-bit datapath files
package c8dp_pkg;
  typedef enum logic [4:0] {
    OP_IDLE  = 5'h00, OP_MOVE = 5'h01, OP_PROD = 5'h02, OP_NEG  = 5'h03,
    OP_OR    = 5'h04, OP_XOR  = 5'h05, OP_SUB  = 5'h06, OP_SBC  = 5'h07,
    OP_SLA   = 5'h08, OP_SLL  = 5'h09, OP_SRL  = 5'h0a, OP_SRA  = 5'h0b,
    OP_RLC   = 5'h0c, OP_RRC  = 5'h0d, OP_SWAP = 5'h0e, OP_CLRC = 5'h0f,
    OP_SETC  = 5'h10, OP_ION  = 5'h11, OP_IOFF = 5'h12, OP_TRAP = 5'h13,
    OP_HALT  = 5'h14, OP_POP  = 5'h15, OP_PUSH = 5'h16, OP_RSP  = 5'h17,
    OP_TEST  = 5'h18, OP_BR   = 5'h19
  } c8dp_op_t;
  // operand select; for push and pop the last code means the flags register
  typedef enum logic [1:0] {
    SEL_A = 2'h0, SEL_X = 2'h1, SEL_Y = 2'h2, SEL_M = 2'h3
  } c8dp_sel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_POPRD = 2'b10, ST_HALT = 2'b11
  } c8dp_st_t;
endpackage

// ==== src/c8dp_stk_if.sv ====
// stack memory port between core and stack memory
`timescale 1ns/1ps
interface c8dp_stk_if;
  logic       we;
  logic [5:0] waddr;
  logic [7:0] wdata;
  logic [5:0] raddr;
  logic [7:0] rdata;
  modport core (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== src/c8dp_stack_mem.sv ====
// stack memory with registered read data
`timescale 1ns/1ps
`include "c8dp_map.svh"
module c8dp_stack_mem (
  input  wire logic   clk_in,
  c8dp_stk_if.mem     bus
);
  logic [7:0] mem_q [`C8DP_STK_DEP];

  // no reset: contents are undefined until pushed
  always_ff @(posedge clk_in)
  begin
    if (bus.we)
    begin
      mem_q[bus.waddr] <= bus.wdata;
    end
    bus.rdata <= mem_q[bus.raddr];
  end
endmodule // c8dp_stack_mem

// ==== bench/cpu8_instruction_subset_datapath_tb.sv ====
// self-checking bench for the 8-bit execution datapath, driven over apb
`timescale 1ns/1ps
`include "c8dp_map.svh"
module cpu8_instruction_subset_datapath_tb;
  typedef struct {logic chk; logic err; logic [31:0] d; string nm;} c8dp_note_t;
  logic        clk_in  = 1'b0;
  logic        nrst_in = 1'b0;
  logic        psel    = 1'b0, penable = 1'b0, pwrite = 1'b0, irq = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, swi, halted;
  integer      checked = 0, mismatches = 0, swi_n = 0, exp_swi = 0, seed = 32'h0a27;
  logic [15:0] pc_m    = 16'h0000;
  c8dp_note_t  notes[$];
  c8dp_note_t  nt;

  always #10 clk_in = ~clk_in;

  c8dp_core u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_in(irq), .swi_out(swi),
    .halted_out(halted));

  // ==========================================================
  // reference model and helpers
  function automatic logic [23:0] model(input c8dp_pkg::c8dp_op_t op,
    input logic [7:0] a, input logic [7:0] x, input logic [7:0] m, input logic [5:0] f);
    logic [7:0] r;
    logic [5:0] g;
    logic [8:0] t;
    logic       nz;
    r = a;
    g = f;
    nz = 1'b1;
    case (op)
      c8dp_pkg::OP_MOVE: r = m;
      c8dp_pkg::OP_PROD:
      begin
        {x, r} = x * a;
        g[4] = 1'b0;
        g[0] = 1'b0;
        nz = 1'b0;
      end
      c8dp_pkg::OP_NEG:
      begin
        r = 8'h00 - a;
        g[0] = (r != 8'h00);
      end
      c8dp_pkg::OP_OR: r = a | m;
      c8dp_pkg::OP_XOR: r = a ^ m;
      c8dp_pkg::OP_SUB, c8dp_pkg::OP_SBC:
      begin
        t = {1'b0, a} - {1'b0, m} - {8'h00, f[0] & (op == c8dp_pkg::OP_SBC)};
        r = t[7:0];
        g[0] = t[8];
      end
      c8dp_pkg::OP_SLA, c8dp_pkg::OP_SLL: {g[0], r} = {a, 1'b0};
      c8dp_pkg::OP_SRL: {r, g[0]} = {1'b0, a};
      c8dp_pkg::OP_SRA: {r, g[0]} = {a[7], a};
      c8dp_pkg::OP_RLC: {g[0], r} = {a, f[0]};
      c8dp_pkg::OP_RRC: {r, g[0]} = {f[0], a};
      c8dp_pkg::OP_SWAP: r = {a[3:0], a[7:4]};
      c8dp_pkg::OP_TEST: r = a;
      c8dp_pkg::OP_CLRC: {nz, g[0]} = 2'b00;
      c8dp_pkg::OP_SETC: {nz, g[0]} = 2'b01;
      c8dp_pkg::OP_ION: {nz, g[5], g[3]} = 3'b010;
      c8dp_pkg::OP_IOFF, c8dp_pkg::OP_TRAP: {nz, g[5], g[3]} = 3'b011;
      default: nz = 1'b0;
    endcase
    if (nz)
    begin
      g[2] = r[7];
      g[1] = (r == 8'h00);
    end
    return {x, r, 2'b00, g};
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ==========================================================
  // apb master: holds the request until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    // no local limit: only the watchdog ends a wait for the slave
    while (pready !== 1'b1)
    begin
      @(posedge clk_in);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    xfer(1'b1, a, wd, dummy);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] dummy;
    notes.push_back('{1'b1, 1'b0, e, nm});
    xfer(1'b0, a, 32'h0, dummy);
  endtask

  // busy polling is bounded so a stuck core fails the busy clear check, not a hang
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 50 && s[0] !== 1'b0; i++)
    begin
      notes.push_back('{1'b0, 1'b0, 32'h0, "poll"});
      xfer(1'b0, `C8DP_OFF_STAT, 32'h0, s);
    end
    check("busy clear", 32'h0, {31'h0, s[0]});
  endtask

  task automatic cmd(input logic [4:0] op, input logic [1:0] ds, input logic [1:0] sr);
    wr(`C8DP_OFF_CMD, {18'h0, sr, 2'b00, ds, 3'b000, op});
    pc_m = pc_m + 16'h1;
    wait_idle();
  endtask

  // ==========================================================
  // output watcher: takes the oldest note at every completed read
  always @(posedge clk_in)
  begin
    if (swi === 1'b1)
      swi_n++;
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
    begin
      nt = notes.pop_front();
      if (nt.chk)
      begin
        check({nt.nm, " err"}, {31'h0, nt.err}, {31'h0, pslverr});
        if (!nt.err)
          check(nt.nm, nt.d, prdata);
      end
    end
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #400000;
    mismatches++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [23:0] e;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(`C8DP_OFF_FLAGS, 32'h28, "flags rst");
    rd(`C8DP_OFF_SP, 32'h3f, "sp rst");
    rd(`C8DP_OFF_PC, 32'h0, "pc rst");
    notes.push_back('{1'b1, 1'b1, 32'h0, "unmapped"});
    xfer(1'b0, 8'h40, 32'h0, d);
    for (int p = 0; p < 2; p++)
      for (int k = 0; k < 25; k++)
        if (k < 20 || k == 24)
        begin
          d = $random(seed);
          wr(`C8DP_OFF_A, {24'h0, d[7:0]});
          wr(`C8DP_OFF_X, {24'h0, d[15:8]});
          wr(`C8DP_OFF_OPND, {24'h0, d[23:16]});
          wr(`C8DP_OFF_FLAGS, {26'h0, d[29:24]});
          cmd(k[4:0], c8dp_pkg::SEL_A, c8dp_pkg::SEL_M);
          e = model(c8dp_pkg::c8dp_op_t'(k[4:0]), d[7:0], d[15:8], d[23:16], d[29:24]);
          if (k == 19)
            exp_swi++;
          rd(`C8DP_OFF_A, {24'h0, e[15:8]}, "acc");
          rd(`C8DP_OFF_X, {24'h0, e[23:16]}, "x");
          rd(`C8DP_OFF_FLAGS, {24'h0, e[7:0]}, "flags");
          rd(`C8DP_OFF_PC, {16'h0, pc_m}, "pc");
        end
    check("swi pulses", exp_swi, swi_n);
    for (int k = 0; k < 4; k++)
    begin
      d = $random(seed);
      wr(`C8DP_OFF_FLAGS, {30'h0, k[1:0]});
      wr(`C8DP_OFF_OPND, {24'h0, d[7:0]});
      cmd(5'h19, c8dp_pkg::SEL_A, c8dp_pkg::SEL_M);
      if (k != 0)
        pc_m = pc_m + {{8{d[7]}}, d[7:0]};
      rd(`C8DP_OFF_PC, {16'h0, pc_m}, "pc br");
      rd(`C8DP_OFF_STAT, {29'h0, k != 0, 2'b00}, "br taken");
    end
    d = $random(seed);
    wr(`C8DP_OFF_FLAGS, 32'h15);
    wr(`C8DP_OFF_A, {24'h0, d[7:0]});
    cmd(5'h16, c8dp_pkg::SEL_A, c8dp_pkg::SEL_A);
    rd(`C8DP_OFF_SP, 32'h3e, "sp push");
    rd(`C8DP_OFF_FLAGS, 32'h15, "flags push");
    wr(`C8DP_OFF_SP, 32'h0);
    cmd(5'h15, c8dp_pkg::SEL_M, c8dp_pkg::SEL_M);
    rd(`C8DP_OFF_FLAGS, {26'h0, d[5:0]}, "flags pop");
    rd(`C8DP_OFF_SP, 32'h3f, "sp pop");
    cmd(5'h16, c8dp_pkg::SEL_A, c8dp_pkg::SEL_A);
    cmd(5'h15, c8dp_pkg::SEL_X, c8dp_pkg::SEL_X);
    rd(`C8DP_OFF_X, {24'h0, d[7:0]}, "x pop");
    rd(`C8DP_OFF_FLAGS, {26'h0, d[5:0]}, "flags kept");
    cmd(5'h16, c8dp_pkg::SEL_A, c8dp_pkg::SEL_A);
    cmd(5'h17, c8dp_pkg::SEL_A, c8dp_pkg::SEL_A);
    rd(`C8DP_OFF_SP, 32'h3f, "sp reload");
    wr(`C8DP_OFF_Y, {24'h0, d[7:0]});
    cmd(5'h0e, c8dp_pkg::SEL_Y, c8dp_pkg::SEL_Y);
    rd(`C8DP_OFF_Y, {24'h0, d[3:0], d[7:4]}, "y swap");
    cmd(5'h01, c8dp_pkg::SEL_X, c8dp_pkg::SEL_Y);
    rd(`C8DP_OFF_X, {24'h0, d[3:0], d[7:4]}, "x load");
    wr(`C8DP_OFF_FLAGS, 32'h3f);
    wr(`C8DP_OFF_CMD, 32'h14);
    pc_m = pc_m + 16'h1;
    for (int i = 0; i < 20 && halted !== 1'b1; i++)
      @(posedge clk_in);
    check("halted", 32'h1, {31'h0, halted});
    irq <= 1'b1;
    for (int i = 0; i < 20 && halted !== 1'b0; i++)
      @(posedge clk_in);
    irq <= 1'b0;
    check("resumed", 32'h0, {31'h0, halted});
    wait_idle();
    rd(`C8DP_OFF_FLAGS, 32'h37, "flags halt");
    rd(`C8DP_OFF_PC, {16'h0, pc_m}, "pc halt");
    finish_test();
  end
endmodule // cpu8_instruction_subset_datapath_tb
